/* File: three_wire_serial_io_port.sv */
//Contract
//(R1) pin-select bit 3 routes async transmit out
//(R2) direction bit 0 output, 1 input
//(R3) direction register resets to all ones
//(R4) master clock: direction 0, latch 1
//(R5) data out pin: direction 0, latch 0
//(R6) slave pins: clock and data directions 1
//(R7) enable clear stops, clears busy and shifter
//(R8) port use needs mode register zero
//(R9) configure clock, mode, enable, then start
//(R10) transmit mode: buffer write starts transfer
//(R11) receive mode: shifter read starts transfer
//(R12) eight bits per transfer, clock synchronous
//(R13) busy flag bit 0 set at start
//(R14) after eight bits: done flag, busy clear
//(R15) no register access while busy
//(R16) slave needs clock source code 111
//(R17) clock pin as port needs polarity 0
//(R18) mode bits 7,6,4,0; others read zero
//(R19) clock select: polarity 4, source 2..0
//(R20) polarity and phase pick timing type
//(R21) port function resets zero, bits 6,3
//(R22) bit order 0 msb, 1 lsb first
//(R23) source divides by 2^(code+1), 111 external
//(R24) receive-only holds data out low
//(R25) data out holds last bit after transfer
//(R26) shifter loads buffer, shifts input in
`timescale 1ns/1ps
module three_wire_serial_io_port (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    input  wire logic        async_transmit_out,
    input  wire logic        second_async_transmit_out,
    output logic             transfer_done_irq_flag
);

    serial_io_pkg::mode_s       mode;
    serial_io_pkg::clk_sel_s    clk_sel;
    serial_io_pkg::xfer_state_e state;

    logic [7:0] port_func;
    logic [7:0] port_dir;
    logic [7:0] port_latch;
    logic [7:0] tx_buf;
    logic [7:0] shifter;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic       ext_clk_prev;
    logic       sck_int;
    logic       serial_data_out;
    logic [6:0] div_cnt;
    logic [3:0] bit_cnt;

    // register decode
    wire wr_func  = wr && addr == serial_io_pkg::ADDR_PORT_FUNC;
    wire wr_dir   = wr && addr == serial_io_pkg::ADDR_PORT_DIR;
    wire wr_latch = wr && addr == serial_io_pkg::ADDR_PORT_LATCH;
    wire wr_mode  = wr && addr == serial_io_pkg::ADDR_MODE;
    wire wr_csel  = wr && addr == serial_io_pkg::ADDR_CLK_SEL;
    wire wr_tx    = wr && addr == serial_io_pkg::ADDR_TX_BUF;
    wire wr_done  = wr && addr == serial_io_pkg::ADDR_DONE_FLAG;
    wire rd_shift = rd && addr == serial_io_pkg::ADDR_SHIFT;

    wire busy    = state == serial_io_pkg::ST_RUN;
    wire ext_clk = clk_sel.source == serial_io_pkg::CLK_SRC_EXT;
    wire idle_lv = ~clk_sel.polarity; // R20

    // start triggers
    wire start_tx = wr_tx && mode.enable && mode.tx_mode && !busy; // R10
    wire start_rx = rd_shift && mode.enable && !mode.tx_mode
                    && !busy; // R11
    wire start    = start_tx || start_rx;

    // internal clock divider: half period of 2^code cycles
    wire [6:0] div_mask = serial_io_pkg::DIV_ALL_ONES
                          >> (serial_io_pkg::CLK_SRC_EXT
                              - clk_sel.source); // R23
    wire       div_tick = (div_cnt & div_mask) == div_mask;

    // external clock edge taken from the second sync stage only
    // slave edges arrive three cycles late, so half periods must be longer
    wire ext_now  = pin_sync[serial_io_pkg::PIN_CLK];
    wire ext_edge = ext_now != ext_clk_prev;

    // leading edge leaves the idle level, trailing edge returns to it
    wire m_edge   = busy && !ext_clk && div_tick;
    wire lead     = ext_clk ? (busy && ext_edge && ext_clk_prev == idle_lv)
                            : (m_edge && sck_int == idle_lv); // R20
    wire trail    = ext_clk ? (busy && ext_edge && ext_clk_prev != idle_lv)
                            : (m_edge && sck_int != idle_lv);

    // phase 0: drive on leading, sample on trailing; phase 1: reverse
    wire drive_ev  = clk_sel.phase ? trail : lead; // R20
    wire sample_ev = clk_sel.phase ? lead : trail; // R12
    wire last_bit  = bit_cnt == serial_io_pkg::BITS_PER_XFR;
    // in phase 0 the closing trailing edge also samples the eighth bit
    wire [3:0] bits_taken = sample_ev ? bit_cnt + 4'h1 : bit_cnt;
    wire finish    = trail
                     && bits_taken == serial_io_pkg::BITS_PER_XFR; // R14

    // a buffer write that starts a transfer has not reached tx_buf yet
    wire [7:0] load_val  = start_tx ? wdata : tx_buf; // R26
    wire [7:0] first_src = start ? load_val : shifter;
    wire       out_bit   = mode.lsb_first ? first_src[0]
                                          : first_src[7]; // R22
    wire       si_bit    = pin_sync[serial_io_pkg::PIN_DIN];
    wire [7:0] shifted   = mode.lsb_first ? {si_bit, shifter[7:1]}
                                          : {shifter[6:0], si_bit}; // R26

    wire [7:0] mode_rd = {mode.enable, mode.tx_mode, 1'b0,
                          mode.lsb_first, 3'b000, busy}; // R18
    wire [7:0] csel_rd = {3'b000, clk_sel.polarity, clk_sel.phase,
                          clk_sel.source}; // R19

    logic [7:0] next_rdata;
    always_comb begin
        unique case (addr)
            serial_io_pkg::ADDR_PORT_FUNC:  next_rdata = port_func;
            serial_io_pkg::ADDR_PORT_DIR:   next_rdata = port_dir;
            serial_io_pkg::ADDR_PORT_LATCH: next_rdata = port_latch;
            serial_io_pkg::ADDR_MODE:       next_rdata = mode_rd;
            serial_io_pkg::ADDR_CLK_SEL:    next_rdata = csel_rd;
            serial_io_pkg::ADDR_TX_BUF:     next_rdata = tx_buf;
            serial_io_pkg::ADDR_SHIFT:      next_rdata = shifter;
            serial_io_pkg::ADDR_DONE_FLAG:
                next_rdata = {7'h00, transfer_done_irq_flag};
            default:                        next_rdata = 8'h00;
        endcase
    end

    // pin muxing; latch gates the clock and is or-ed with the data out
    wire        sck_pin   = ext_clk ? idle_lv : sck_int;
    wire        so_pin    = mode.tx_mode & serial_data_out; // R24
    logic [7:0] next_pin_out;
    always_comb begin
        next_pin_out = port_latch;
        if (mode.enable) begin
            next_pin_out[serial_io_pkg::PIN_CLK] =
                port_latch[serial_io_pkg::PIN_CLK] & sck_pin; // R4
            next_pin_out[serial_io_pkg::PIN_DOUT] =
                port_latch[serial_io_pkg::PIN_DOUT] | so_pin; // R5
        end else begin
            next_pin_out[serial_io_pkg::PIN_CLK] =
                port_latch[serial_io_pkg::PIN_CLK]
                & ~clk_sel.polarity; // R17
        end
        if (port_func[serial_io_pkg::FUNC_TX_BIT]) begin
            next_pin_out[serial_io_pkg::PIN_DOUT] =
                async_transmit_out; // R1
        end
        if (port_func[serial_io_pkg::FUNC_TX2_BIT]) begin
            next_pin_out[serial_io_pkg::PIN_DOUT2] =
                second_async_transmit_out;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= serial_io_pkg::PORT_LATCH_RESET;
            pin_oe  <= 8'h00;
            rdata   <= 8'h00;
        end else begin
            pin_out <= next_pin_out;
            pin_oe  <= ~port_dir; // R2
            rdata   <= rd ? next_rdata : 8'h00;
        end
    end

    // port registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_func  <= serial_io_pkg::PORT_FUNC_RESET; // R21
            port_dir   <= serial_io_pkg::PORT_DIR_RESET; // R3
            port_latch <= serial_io_pkg::PORT_LATCH_RESET;
        end else begin
            if (wr_func)
                port_func <= wdata & serial_io_pkg::PORT_FUNC_MASK; // R21
            if (wr_dir)
                port_dir <= wdata; // R2
            if (wr_latch)
                port_latch <= wdata;
        end
    end

    // control registers; changes during a transfer are software's fault
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode    <= '0;
            clk_sel <= '0;
            tx_buf  <= serial_io_pkg::DATA_RESET;
        end else begin
            if (wr_mode) begin
                mode.enable    <= wdata[serial_io_pkg::MODE_ENABLE_BIT];
                mode.tx_mode   <= wdata[serial_io_pkg::MODE_TXMODE_BIT];
                mode.lsb_first <= wdata[serial_io_pkg::MODE_DIR_BIT];
            end
            if (wr_csel) begin
                clk_sel.polarity <= wdata[serial_io_pkg::CLK_POL_BIT];
                clk_sel.phase    <= wdata[serial_io_pkg::CLK_PHASE_BIT];
                clk_sel.source   <= wdata[serial_io_pkg::CLK_SRC_MSB:0];
            end
            if (wr_tx && !busy)
                tx_buf <= wdata;
        end
    end

    // done flag: hardware set beats a software clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            transfer_done_irq_flag <= 1'b0;
        else if (finish)
            transfer_done_irq_flag <= 1'b1; // R14
        else if (wr_done && wdata[0])
            transfer_done_irq_flag <= 1'b0;
    end

    // transfer engine; enable low clears it on the next edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state           <= serial_io_pkg::ST_IDLE;
            shifter         <= serial_io_pkg::DATA_RESET;
            bit_cnt         <= 4'h0;
            div_cnt         <= 7'h00;
            sck_int         <= 1'b1;
            ext_clk_prev    <= 1'b1;
            serial_data_out <= 1'b0;
        end else if (!mode.enable) begin
            state           <= serial_io_pkg::ST_IDLE; // R7
            shifter         <= serial_io_pkg::DATA_RESET; // R7
            bit_cnt         <= 4'h0;
            div_cnt         <= 7'h00;
            sck_int         <= idle_lv;
            ext_clk_prev    <= ext_now;
            serial_data_out <= 1'b0;
        end else begin
            ext_clk_prev <= ext_now;
            div_cnt      <= busy ? div_cnt + 7'h01 : 7'h00;
            if (m_edge)
                sck_int <= ~sck_int; // R23
            else if (!busy)
                sck_int <= idle_lv;
            unique case (state)
                serial_io_pkg::ST_IDLE: begin
                    if (start) begin
                        state   <= serial_io_pkg::ST_RUN; // R13
                        shifter <= load_val; // R26
                        bit_cnt <= 4'h0;
                        if (clk_sel.phase)
                            serial_data_out <= out_bit;
                    end
                end
                serial_io_pkg::ST_RUN: begin
                    if (sample_ev) begin
                        shifter <= shifted; // R12
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    // the final trailing edge drives nothing new
                    if (drive_ev && !last_bit)
                        serial_data_out <= out_bit; // R25
                    if (finish)
                        state <= serial_io_pkg::ST_IDLE; // R14
                end
            endcase
        end
    end

endmodule

/* File: serial_io_pkg.sv */
package serial_io_pkg;

    localparam logic [15:0] ADDR_PORT_FUNC  = 16'hFF20;
    localparam logic [15:0] ADDR_PORT_DIR   = 16'hFF21;
    localparam logic [15:0] ADDR_PORT_LATCH = 16'hFF01;
    localparam logic [15:0] ADDR_MODE       = 16'hFF80;
    localparam logic [15:0] ADDR_CLK_SEL    = 16'hFF81;
    localparam logic [15:0] ADDR_TX_BUF     = 16'hFF84;
    localparam logic [15:0] ADDR_SHIFT      = 16'hFF85;
    localparam logic [15:0] ADDR_DONE_FLAG  = 16'hFF86;

    localparam logic [7:0] PORT_FUNC_RESET  = 8'h00;
    localparam logic [7:0] PORT_FUNC_MASK   = 8'h48;
    localparam logic [7:0] PORT_DIR_RESET   = 8'hFF;
    localparam logic [7:0] PORT_LATCH_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET       = 8'h00;

    localparam int MODE_ENABLE_BIT = 7;
    localparam int MODE_TXMODE_BIT = 6;
    localparam int MODE_DIR_BIT    = 4;
    localparam int MODE_BUSY_BIT   = 0;
    localparam int CLK_POL_BIT     = 4;
    localparam int CLK_PHASE_BIT   = 3;
    localparam int CLK_SRC_MSB     = 2;
    localparam int FUNC_TX_BIT     = 3;
    localparam int FUNC_TX2_BIT    = 6;
    localparam int PIN_CLK         = 1;
    localparam int PIN_DIN         = 2;
    localparam int PIN_DOUT        = 3;
    localparam int PIN_DOUT2       = 6;

    localparam logic [2:0] CLK_SRC_EXT  = 3'h7;
    localparam logic [3:0] BITS_PER_XFR = 4'h8;
    localparam logic [6:0] DIV_ALL_ONES = 7'h7F;

    typedef struct packed {
        logic enable;
        logic tx_mode;
        logic lsb_first;
    } mode_s;

    typedef struct packed {
        logic       polarity;
        logic       phase;
        logic [2:0] source;
    } clk_sel_s;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } xfer_state_e;

endpackage

/* File: serial_io_checker.sv */
`timescale 1ns/1ps
module serial_io_checker (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic [7:0]  pin_in,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe,
    input wire logic        async_transmit_out,
    input wire logic        second_async_transmit_out,
    input wire logic        transfer_done_irq_flag
);
    logic [7:0] dir_q;
    logic [7:0] func_q;
    logic [3:0] rises;
    logic       sck_q;
    logic       sin_q;
    wire        wr_dir = wr && addr == serial_io_pkg::ADDR_PORT_DIR;
    wire        wr_func = wr && addr == serial_io_pkg::ADDR_PORT_FUNC;
    wire        start = (wr && addr == serial_io_pkg::ADDR_TX_BUF)
                     || (rd && addr == serial_io_pkg::ADDR_SHIFT);
    // shadow copies let pin and readback checks work without the bodies
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_q <= 8'hFF;
            func_q <= 8'h00;
            rises <= 4'h0;
            sck_q <= 1'b0;
            sin_q <= 1'b0;
        end else begin
            dir_q <= wr_dir ? wdata : dir_q;
            func_q <= wr_func ? (wdata & 8'h48) : func_q;
            // master edges show on the clock pin, slave edges on its input
            rises <= start ? 4'h0 : rises + 4'(pin_out[1] & ~sck_q)
                     + 4'(pin_in[1] & ~sin_q);
            sck_q <= pin_out[1];
            sin_q <= pin_in[1];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    dir_oe_a: assert property (pin_oe == ~$past(dir_q))
        else $error("output enables differ from direction");
    dir_read_a: assert property (rd && addr == serial_io_pkg::ADDR_PORT_DIR
        |=> rdata == $past(dir_q))
        else $error("direction readback wrong");
    func_mask_a: assert property (rd && addr == serial_io_pkg::ADDR_PORT_FUNC
        |=> rdata == $past(func_q))
        else $error("pin select readback wrong");
    mode_zero_a: assert property (rd && addr == serial_io_pkg::ADDR_MODE
        |=> (rdata & 8'h2E) == 8'h00)
        else $error("unused mode bits not zero");
    flag_hold_a: assert property (transfer_done_irq_flag
        && !(wr && addr == serial_io_pkg::ADDR_DONE_FLAG)
        |=> transfer_done_irq_flag)
        else $error("done flag dropped without clear");
    tx_route_a: assert property ($past(func_q[3])
        |-> pin_out[3] == $past(async_transmit_out))
        else $error("async transmit not routed to pin");
    bit_count_a: assert property ($rose(transfer_done_irq_flag)
        |-> ##[1:3] rises == 4'h8)
        else $error("transfer did not take eight clocks");
endmodule

bind three_wire_serial_io_port serial_io_checker chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe),
    .async_transmit_out(async_transmit_out),
    .second_async_transmit_out(second_async_transmit_out),
    .transfer_done_irq_flag(transfer_done_irq_flag)
);

/* File: periph_model.sv */
`timescale 1ns/1ps
module periph_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       arm,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic [7:0] reply,
    output logic            miso,
    output logic [7:0]      got
);
    int n = 0;
    // types 2 and 3 sample on the falling clock, types 1 and 4 rising
    wire swap = cpol ^ cpha;
    initial miso = 1'b0;
    initial got = 8'h00;
    always @(negedge sck) begin
        if (arm && n < 8) begin
            if (swap) begin
                got <= {got[6:0], mosi};
                n <= n + 1;
            end else begin
                miso <= reply[7 - n];
            end
        end
    end
    always @(posedge sck) begin
        if (arm && n < 8) begin
            if (swap) begin
                miso <= reply[7 - n];
            end else begin
                got <= {got[6:0], mosi};
                n <= n + 1;
            end
        end
    end
    // first bit stands at select for phase 1; a release shows the inverse
    always @(arm) begin
        n <= 0;
        miso <= arm ? reply[7] : ~miso;
    end
endmodule

/* File: three_wire_serial_io_port_tb.sv */
`timescale 1ns/1ps
module three_wire_serial_io_port_tb;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        atx = 1'b0;
    logic        atx2 = 1'b0;
    logic        arm = 1'b0;
    logic        miso;
    logic [7:0]  reply = 8'h00;
    logic [7:0]  got;
    logic [7:0]  rdata;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic        flag;
    logic        ext_sck = 1'b1;
    logic        slave = 1'b0;
    logic        cpol = 1'b0;
    logic        cpha = 1'b0;
    wire         link_sck = slave ? ext_sck : pin_out[1];
    int          error_cnt = 0;
    int          compares = 0;
    int          cycles = 0;
    always #50 ref_clk = ~ref_clk;
    three_wire_serial_io_port uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata),
        .pin_in({5'h00, miso, ext_sck, 1'b0}),
        .pin_out(pin_out), .pin_oe(pin_oe), .async_transmit_out(atx),
        .second_async_transmit_out(atx2), .transfer_done_irq_flag(flag));
    periph_model peer (.sck(link_sck), .mosi(pin_out[3]), .arm(arm),
        .cpol(cpol), .cpha(cpha), .reply(reply), .miso(miso), .got(got));
    task automatic complete_run;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            complete_run;
        end
    end
    function automatic logic [7:0] rev8(input logic [7:0] v);
        return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
    endfunction
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        check(rdata, e);
    endtask
    task automatic wait_flag;
        int n;
        n = 0;
        while (flag !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check({7'h00, flag}, 8'h01);
        // in master phase 0 runs the peer takes the last bit one cycle after the flag
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic pins(input logic v, input logic [7:0] e);
        @(posedge ref_clk);
        atx <= v;
        atx2 <= v;
        repeat (2) @(posedge ref_clk);
        #1;
        check(pin_out & 8'h48, e);
    endtask
    task automatic t_regs;
        rd_chk(serial_io_pkg::ADDR_PORT_FUNC, 8'h00);
        rd_chk(serial_io_pkg::ADDR_PORT_DIR, 8'hFF);
        rd_chk(serial_io_pkg::ADDR_MODE, 8'h00);
        rd_chk(16'h1234, 8'h00);
        wr_reg(serial_io_pkg::ADDR_PORT_FUNC, 8'hFF);
        rd_chk(serial_io_pkg::ADDR_PORT_FUNC, 8'h48);
        wr_reg(serial_io_pkg::ADDR_MODE, 8'hFF);
        rd_chk(serial_io_pkg::ADDR_MODE, 8'hD0);
        wr_reg(serial_io_pkg::ADDR_MODE, 8'h00);
        pins(1'b1, 8'h48);
        pins(1'b0, 8'h00);
        wr_reg(serial_io_pkg::ADDR_PORT_FUNC, 8'h00);
        wr_reg(serial_io_pkg::ADDR_PORT_DIR, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1;
        check(pin_oe, 8'hFF);
    endtask
    task automatic t_xfer(input logic l, input logic [7:0] tx, rp, cs);
        reply = rp;
        {cpol, cpha} = cs[4:3];
        wr_reg(serial_io_pkg::ADDR_PORT_LATCH, 8'h02);
        wr_reg(serial_io_pkg::ADDR_PORT_DIR, 8'hF5);
        wr_reg(serial_io_pkg::ADDR_CLK_SEL, cs);
        wr_reg(serial_io_pkg::ADDR_MODE, {3'h2, l, 4'h0});
        wr_reg(serial_io_pkg::ADDR_MODE, {3'h6, l, 4'h0});
        arm = 1'b1;
        wr_reg(serial_io_pkg::ADDR_TX_BUF, tx);
        wait_flag;
        arm = 1'b0;
        check(got, l ? rev8(tx) : tx);
        check({7'h00, pin_out[3]}, {7'h00, l ? tx[7] : tx[0]});
        rd_chk(serial_io_pkg::ADDR_SHIFT, l ? rev8(rp) : rp);
        wr_reg(serial_io_pkg::ADDR_DONE_FLAG, 8'h01);
        wr_reg(serial_io_pkg::ADDR_MODE, 8'h00);
    endtask
    task automatic t_rx;
        reply = 8'hC3;
        wr_reg(serial_io_pkg::ADDR_MODE, 8'h80);
        arm = 1'b1;
        rd_chk(serial_io_pkg::ADDR_SHIFT, 8'h00);
        repeat (20) @(posedge ref_clk);
        #1;
        check({7'h00, pin_out[3]}, 8'h00);
        wait_flag;
        arm = 1'b0;
        check(got, 8'h00);
        wr_reg(serial_io_pkg::ADDR_DONE_FLAG, 8'h01);
        arm = 1'b1;
        rd_chk(serial_io_pkg::ADDR_SHIFT, 8'hC3);
        repeat (12) @(posedge ref_clk);
        arm = 1'b0;
        wr_reg(serial_io_pkg::ADDR_MODE, 8'h00);
        repeat (100) @(posedge ref_clk);
        #1;
        check({7'h00, flag}, 8'h00);
        rd_chk(serial_io_pkg::ADDR_SHIFT, 8'h00);
        rd_chk(serial_io_pkg::ADDR_MODE, 8'h00);
    endtask
    task automatic t_slave;
        reply = 8'hE1;
        {cpol, cpha} = 2'b00;
        slave = 1'b1;
        wr_reg(serial_io_pkg::ADDR_PORT_DIR, 8'hF7);
        wr_reg(serial_io_pkg::ADDR_CLK_SEL, 8'h07);
        wr_reg(serial_io_pkg::ADDR_MODE, 8'h40);
        wr_reg(serial_io_pkg::ADDR_MODE, 8'hC0);
        arm = 1'b1;
        wr_reg(serial_io_pkg::ADDR_TX_BUF, 8'h4B);
        repeat (8) begin
            repeat (8) @(posedge ref_clk);
            ext_sck <= 1'b0;
            repeat (8) @(posedge ref_clk);
            ext_sck <= 1'b1;
        end
        wait_flag;
        arm = 1'b0;
        slave = 1'b0;
        check(got, 8'h4B);
        check({7'h00, pin_out[3]}, 8'h01);
        rd_chk(serial_io_pkg::ADDR_SHIFT, 8'hE1);
        wr_reg(serial_io_pkg::ADDR_DONE_FLAG, 8'h01);
        wr_reg(serial_io_pkg::ADDR_MODE, 8'h00);
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs;
        t_xfer(1'b1, 8'h96, 8'h3C, 8'h02);
        t_xfer(1'b0, 8'h96, 8'h5A, 8'h0A);
        t_xfer(1'b0, 8'h69, 8'hA5, 8'h12);
        t_rx;
        t_slave;
        complete_run;
    end
endmodule
